// [logic/ppio_pkg.sv]
// Constants, register map and types of the parallel port and pin control block.
// Assumes a byte-wide register port with single-cycle strobes.
package ppio_pkg;

	// ****************************************************************
	// Port geometry
	// ****************************************************************
	localparam int PORT_CNT = 3;
	localparam int PIN_W = 22;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int PA_W = 8;
	localparam int PB_W = 8;
	localparam int PC_W = 6;
	localparam int PA_BASE = 0;
	localparam int PB_BASE = PA_BASE + PA_W;
	localparam int PC_BASE = PB_BASE + PB_W;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [ADDR_W-1:0] LP_BASE = 8'h00;
	localparam logic [ADDR_W-1:0] LP_STRIDE = 8'h02;
	localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_DIR = 8'h01;
	localparam logic [ADDR_W-1:0] HP_BASE = 8'h10;
	localparam logic [ADDR_W-1:0] HP_STRIDE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PULL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SLEW = 8'h01;
	localparam logic [ADDR_W-1:0] OFS_DRIVE = 8'h02;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [PIN_W-1:0] RST_PINS = 22'h000000;
	localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;

	typedef enum logic [2:0] {
		PPIO_K_DATA = 3'b000,
		PPIO_K_DIR = 3'b001,
		PPIO_K_PULL = 3'b010,
		PPIO_K_SLEW = 3'b011,
		PPIO_K_DRIVE = 3'b100
	} ppio_kind_t;

	typedef struct packed {
		logic valid;
		logic [1:0] port;
		ppio_kind_t kind;
	} ppio_dec_t;

	typedef struct packed {
		logic [PIN_W-1:0] data;
		logic [PIN_W-1:0] dir;
		logic [PIN_W-1:0] pull;
		logic [PIN_W-1:0] slew;
		logic [PIN_W-1:0] drive;
		logic [PIN_W-1:0] pad_out;
		logic [PIN_W-1:0] pad_oe;
		logic [PIN_W-1:0] pad_ie;
		logic [PIN_W-1:0] pad_pu;
		logic [PIN_W-1:0] pad_slew;
		logic [PIN_W-1:0] pad_hd;
		logic [PIN_W-1:0] periph_in;
		logic [DATA_W-1:0] rdata;
	} ppio_state_t;

	function automatic int port_base(input logic [1:0] p);
		case (p)
			2'h0: port_base = PA_BASE;
			2'h1: port_base = PB_BASE;
			default: port_base = PC_BASE;
		endcase
	endfunction

	function automatic int port_width(input logic [1:0] p);
		case (p)
			2'h0: port_width = PA_W;
			2'h1: port_width = PB_W;
			default: port_width = PC_W;
		endcase
	endfunction

	function automatic ppio_dec_t decode(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		logic [ADDR_W-1:0] sel;
		logic [ADDR_W-1:0] idx;
		decode = '{valid: 1'b0, port: 2'h0, kind: PPIO_K_DATA};
		if (a < HP_BASE) begin
			off = a - LP_BASE;
			idx = off / LP_STRIDE;
			sel = off % LP_STRIDE;
			decode.valid = (idx < ADDR_W'(PORT_CNT));
			decode.port = idx[1:0];
			decode.kind = (sel == OFS_DIR) ? PPIO_K_DIR : PPIO_K_DATA;
		end else begin
			off = a - HP_BASE;
			idx = off / HP_STRIDE;
			sel = off % HP_STRIDE;
			decode.valid = (idx < ADDR_W'(PORT_CNT)) && (sel <= OFS_DRIVE);
			decode.port = idx[1:0];
			case (sel)
				OFS_PULL: decode.kind = PPIO_K_PULL;
				OFS_SLEW: decode.kind = PPIO_K_SLEW;
				default: decode.kind = PPIO_K_DRIVE;
			endcase
		end
	endfunction

endpackage

// [logic/ppio_pin.sv]
// One pin slice: ownership arbitration, buffer enables and pad controls.
// Purely combinational; the top module registers every result.
`timescale 1ns/100ps
module ppio_pin (
	input wire logic dir, // Direction bit
	input wire logic latch, // Output data latch
	input wire logic pull, // Pull-up enable bit
	input wire logic slew, // Slew limit bit
	input wire logic drive, // High drive bit
	input wire logic periph_en, // Shared digital function owns pin
	input wire logic periph_oe, // Shared function output enable
	input wire logic periph_out, // Shared function output data
	input wire logic analog_en, // Analog function owns pin
	input wire logic output_only, // Pin has no input buffer
	input wire logic pad_in, // Pin level
	output logic oe, // Output buffer enable
	output logic out, // Output buffer data
	output logic ie, // Input buffer enable
	output logic pu, // Pull-up connected
	output logic slew_on, // Slew limiting active
	output logic hd, // High drive active
	output logic in_bit, // Gated pin level
	output logic rd_bit // Data register read value
);

	always_comb begin
		ie = !(analog_en || output_only);
		in_bit = ie ? pad_in : 1'b0;
		if (analog_en) begin
			oe = 1'b0;
		end else if (periph_en) begin
			oe = periph_oe;
		end else begin
			oe = dir;
		end
		out = periph_en ? periph_out : latch;
		pu = pull && !oe && !analog_en;
		slew_on = slew && oe;
		hd = drive && oe;
		rd_bit = dir ? latch : in_bit;
	end

endmodule

// [logic/ppio_port.sv]
// Top of the parallel port block: three ports, 22 pins, register port and pads.
// Assumes a byte-wide register master with one-cycle strobes; pins are synchronous.
`timescale 1ns/100ps
// Behaviour
// - Reset turns every pin into an input; reset does not gate the shared function enables.
// - Reset clears slew, high drive and pull-up bits of every pin.
// - An enabled shared peripheral overrides the general-purpose pin function.
// - Direction bit enables output buffer and picks data read source.
// - Input buffer always on except analog ownership or output-only pins.
// - Shared digital function drives output enable; direction still picks read.
// - Analog function disables both input and output buffers.
// - Input-direction bit with disabled input buffer reads zero.
// - Analog function wins over an alternate digital function.
// - Each pin has its own pull-up enable bit.
// - Pull-up forced off whenever the pin drives as output.
// - Pull-up forced off while an analog function owns the pin.
// - Per-pin slew limit bit; no effect on inputs.
// - Per-pin drive bit selects high or low output drive.
// - Pull, slew and drive bits sit in a separate high-page set.
// - Three ports with 22 pins in total.
module ppio_port #(
	parameter logic [ppio_pkg::PIN_W-1:0] OUTPUT_ONLY_MASK = 22'h000000
) (
	input wire logic clk, // 50 MHz clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic [ppio_pkg::ADDR_W-1:0] reg_addr, // Register address
	input wire logic [ppio_pkg::DATA_W-1:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [ppio_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
	input wire logic [ppio_pkg::PIN_W-1:0] periph_en, // Shared digital function enables
	input wire logic [ppio_pkg::PIN_W-1:0] periph_oe, // Shared function output enables
	input wire logic [ppio_pkg::PIN_W-1:0] periph_out, // Shared function output data
	input wire logic [ppio_pkg::PIN_W-1:0] analog_en, // Analog function enables
	output logic [ppio_pkg::PIN_W-1:0] periph_in, // Gated pin levels to peripherals
	input wire logic [ppio_pkg::PIN_W-1:0] pad_in, // Pin levels
	output logic [ppio_pkg::PIN_W-1:0] pad_out, // Pin output data
	output logic [ppio_pkg::PIN_W-1:0] pad_oe, // Pin output enable
	output logic [ppio_pkg::PIN_W-1:0] pad_ie, // Pin input buffer enable
	output logic [ppio_pkg::PIN_W-1:0] pad_pullup, // Pull-up connect
	output logic [ppio_pkg::PIN_W-1:0] pad_slew, // Slew limiting on
	output logic [ppio_pkg::PIN_W-1:0] pad_high_drive // High drive on
);

	ppio_pkg::ppio_state_t st_r;
	ppio_pkg::ppio_state_t st_nxt;
	logic [ppio_pkg::PIN_W-1:0] oe_c;
	logic [ppio_pkg::PIN_W-1:0] out_c;
	logic [ppio_pkg::PIN_W-1:0] ie_c;
	logic [ppio_pkg::PIN_W-1:0] pu_c;
	logic [ppio_pkg::PIN_W-1:0] slew_c;
	logic [ppio_pkg::PIN_W-1:0] hd_c;
	logic [ppio_pkg::PIN_W-1:0] in_c;
	logic [ppio_pkg::PIN_W-1:0] rd_c;
	ppio_pkg::ppio_dec_t dec;

	// ****************************************************************
	// Pin slices
	// ****************************************************************
	generate
		for (genvar i = 0; i < ppio_pkg::PIN_W; i++) begin : g_pin
			ppio_pin u_pin (
				.dir(st_r.dir[i]),
				.latch(st_r.data[i]),
				.pull(st_r.pull[i]),
				.slew(st_r.slew[i]),
				.drive(st_r.drive[i]),
				.periph_en(periph_en[i]),
				.periph_oe(periph_oe[i]),
				.periph_out(periph_out[i]),
				.analog_en(analog_en[i]),
				.output_only(OUTPUT_ONLY_MASK[i]),
				.pad_in(pad_in[i]),
				.oe(oe_c[i]),
				.out(out_c[i]),
				.ie(ie_c[i]),
				.pu(pu_c[i]),
				.slew_on(slew_c[i]),
				.hd(hd_c[i]),
				.in_bit(in_c[i]),
				.rd_bit(rd_c[i])
			);
		end
	endgenerate

	// ****************************************************************
	// Register access and next state
	// ****************************************************************
	always_comb begin
		int base;
		int width;
		base = 0;
		width = 0;
		dec = ppio_pkg::decode(reg_addr);
		st_nxt = st_r;
		st_nxt.rdata = ppio_pkg::RST_BYTE;
		base = ppio_pkg::port_base(dec.port);
		width = ppio_pkg::port_width(dec.port);
		if (reg_wr && dec.valid) begin
			for (int b = 0; b < ppio_pkg::DATA_W; b++) begin
				if (b < width) begin
					case (dec.kind)
						ppio_pkg::PPIO_K_DATA: st_nxt.data[base+b] = reg_wdata[b];
						ppio_pkg::PPIO_K_DIR: st_nxt.dir[base+b] = reg_wdata[b];
						ppio_pkg::PPIO_K_PULL: st_nxt.pull[base+b] = reg_wdata[b];
						ppio_pkg::PPIO_K_SLEW: st_nxt.slew[base+b] = reg_wdata[b];
						ppio_pkg::PPIO_K_DRIVE: st_nxt.drive[base+b] = reg_wdata[b];
						default: st_nxt.data[base+b] = st_r.data[base+b];
					endcase
				end
			end
		end
		if (reg_rd && dec.valid) begin
			for (int b = 0; b < ppio_pkg::DATA_W; b++) begin
				if (b < width) begin
					case (dec.kind)
						ppio_pkg::PPIO_K_DATA: st_nxt.rdata[b] = rd_c[base+b];
						ppio_pkg::PPIO_K_DIR: st_nxt.rdata[b] = st_r.dir[base+b];
						ppio_pkg::PPIO_K_PULL: st_nxt.rdata[b] = st_r.pull[base+b];
						ppio_pkg::PPIO_K_SLEW: st_nxt.rdata[b] = st_r.slew[base+b];
						ppio_pkg::PPIO_K_DRIVE: st_nxt.rdata[b] = st_r.drive[base+b];
						default: st_nxt.rdata[b] = 1'b0;
					endcase
				end
			end
		end
		st_nxt.pad_out = out_c;
		st_nxt.pad_oe = oe_c;
		st_nxt.pad_ie = ie_c;
		st_nxt.pad_pu = pu_c;
		st_nxt.pad_slew = slew_c;
		st_nxt.pad_hd = hd_c;
		st_nxt.periph_in = in_c;
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r.data <= ppio_pkg::RST_PINS;
			st_r.dir <= ppio_pkg::RST_PINS;
			st_r.pull <= ppio_pkg::RST_PINS;
			st_r.slew <= ppio_pkg::RST_PINS;
			st_r.drive <= ppio_pkg::RST_PINS;
			st_r.pad_out <= ppio_pkg::RST_PINS;
			st_r.pad_oe <= ppio_pkg::RST_PINS;
			st_r.pad_ie <= ppio_pkg::RST_PINS;
			st_r.pad_pu <= ppio_pkg::RST_PINS;
			st_r.pad_slew <= ppio_pkg::RST_PINS;
			st_r.pad_hd <= ppio_pkg::RST_PINS;
			st_r.periph_in <= ppio_pkg::RST_PINS;
			st_r.rdata <= ppio_pkg::RST_BYTE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign pad_out = st_r.pad_out;
	assign pad_oe = st_r.pad_oe;
	assign pad_ie = st_r.pad_ie;
	assign pad_pullup = st_r.pad_pu;
	assign pad_slew = st_r.pad_slew;
	assign pad_high_drive = st_r.pad_hd;
	assign periph_in = st_r.periph_in;

endmodule

// [testbench/ppio_port_assertions.sv]
// Checker of the ppio_port pad and register port relations.
// Bound to every ppio_port; single clock, synchronous reset.
`timescale 1ns/100ps
module ppio_chk #(
	parameter logic [21:0] OUTPUT_ONLY_MASK = 22'h000000
) (
	input wire logic clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic [7:0] reg_addr, // Address
	input wire logic reg_rd, // Read strobe
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic [21:0] periph_en, // Digital owner
	input wire logic [21:0] periph_oe, // Owner enable
	input wire logic [21:0] periph_out, // Owner data
	input wire logic [21:0] analog_en, // Analog owner
	input wire logic [21:0] periph_in, // Gated level
	input wire logic [21:0] pad_in, // Pin level
	input wire logic [21:0] pad_out, // Pad data
	input wire logic [21:0] pad_oe, // Pad enable
	input wire logic [21:0] pad_ie, // Input buffer
	input wire logic [21:0] pad_pullup, // Pull-up
	input wire logic [21:0] pad_slew, // Slew
	input wire logic [21:0] pad_high_drive // Drive
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// ****
	// Assertions
	// ****
	rst_clear_a: assert property ($past(sys_rst) |->
		(pad_oe | pad_pullup | pad_slew | pad_high_drive | periph_in) == 22'h0) else $error("reset");
	analog_owns_a: assert property (($past(analog_en) & (pad_oe | pad_ie | pad_pullup)) == 22'h0)
		else $error("analog pin not released");
	periph_oe_a: assert property (!$past(sys_rst) |->
		((pad_oe ^ $past(periph_oe)) & $past(periph_en) & ~$past(analog_en)) == 22'h0) else $error("oe");
	periph_data_a: assert property (!$past(sys_rst) |->
		((pad_out ^ $past(periph_out)) & $past(periph_en)) == 22'h0) else $error("pad data");
	input_buf_a: assert property (!$past(sys_rst) |->
		pad_ie == ~($past(analog_en) | OUTPUT_ONLY_MASK)) else $error("input buffer");
	gated_in_a: assert property (!$past(sys_rst) |-> periph_in == ($past(pad_in) & pad_ie))
		else $error("gated input");
	pullup_off_a: assert property ((pad_pullup & pad_oe) == 22'h0)
		else $error("pull-up on output");
	drive_out_a: assert property (((pad_slew | pad_high_drive) & ~pad_oe) == 22'h0)
		else $error("slew or drive on input");
	rdata_idle_a: assert property (!$past(reg_rd) || $past(reg_addr) > 8'h1a |-> reg_rdata == 8'h00)
		else $error("read data outside slot");
	cover property ($past(reg_rd) && reg_rdata != 8'h00);
	cover property (pad_high_drive != 22'h0);
	cover property (($past(analog_en) & ~pad_ie) != 22'h0);
endmodule
bind ppio_port ppio_chk #(.OUTPUT_ONLY_MASK(OUTPUT_ONLY_MASK)) i_chk (.clk(clk),
	.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.periph_en(periph_en), .periph_oe(periph_oe), .periph_out(periph_out),
	.analog_en(analog_en), .periph_in(periph_in), .pad_in(pad_in), .pad_out(pad_out),
	.pad_oe(pad_oe), .pad_ie(pad_ie), .pad_pullup(pad_pullup), .pad_slew(pad_slew),
	.pad_high_drive(pad_high_drive));

// [testbench/ppio_pad_model.sv]
// Board side of the pins: drivers, pull-ups and floating lines.
// Clocked by the bench clock; pin levels settle after each edge.
`timescale 1ns/100ps
module ppio_pad_model (
	input wire logic clk, // Clock
	input wire logic [21:0] pad_out, // Device data
	input wire logic [21:0] pad_oe, // Device enable
	input wire logic [21:0] pad_pullup, // Pull-up on
	input wire logic [21:0] ext_en, // Board drives
	input wire logic [21:0] ext_val, // Board value
	output logic [21:0] pad_in // Pin level
);
	logic [21:0] flt = 22'h0;
	// Undriven lines without pull-up change every cycle
	always @(posedge clk) flt <= ~flt;
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
		(~pad_oe & ~ext_en & (pad_pullup | flt));
endmodule

// [testbench/parallel_io_port_pin_control_tb_top.sv]
// Cycle model bench for ppio_port: register walk, random pins, mid-run reset.
// Needs ppio_pad_model on the pins; the checker is bound.
`timescale 1ns/100ps
module parallel_io_port_pin_control_tb_top;
	localparam logic [21:0] OOM = 22'h200000;
	logic clk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [7:0] adr = 8'h00, wd = 8'h00, rdat, er;
	logic [21:0] pe = 22'h0, poe = 22'h0, pov = 22'h0, an = 22'h0, xe = 22'h0, xv = 22'h0, pin, pi;
	logic [21:0] po, oe, ie, pu, sl, hd, ow, ix, rv, v;
	logic [21:0] m [5];
	logic [21:0] e [7];
	int bad_count = 0, cmp_count = 0, seed = 5, k, b, w;
	bit armed = 1'b0;
	initial forever #10 clk = ~clk;
	ppio_port #(.OUTPUT_ONLY_MASK(OOM)) i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(adr),
		.reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .periph_en(pe),
		.periph_oe(poe), .periph_out(pov), .analog_en(an), .periph_in(pi), .pad_in(pin),
		.pad_out(po), .pad_oe(oe), .pad_ie(ie), .pad_pullup(pu), .pad_slew(sl),
		.pad_high_drive(hd));
	ppio_pad_model i_pads (.clk(clk), .pad_out(po), .pad_oe(oe), .pad_pullup(pu),
		.ext_en(xe), .ext_val(xv), .pad_in(pin));
	task chk(input string n, input logic [21:0] x, input logic [21:0] g);
		cmp_count++;
		if (g !== x) begin
			bad_count++;
			$display("BAD %s exp %h got %h", n, x, g);
		end
	endtask
	task report_and_stop;
		$display("Compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task op(input logic w_, input logic r_, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= w_;
		rd <= r_;
		adr <= a;
		wd <= d;
	endtask
	function automatic int kd(input logic [7:0] a);
		if (a < 8'h06)
			return int'(a[0]);
		if (a >= 8'h10 && a <= 8'h1a && a[1:0] != 2'h3)
			return 2 + int'(a[1:0]);
		return -1;
	endfunction
	// ****
	// Cycle model, compared every edge
	// ****
	always @(posedge clk) begin
		if (armed) begin
			chk("pad_oe", e[0], oe);
			chk("pad_out", e[1], po);
			chk("pad_ie", e[2], ie);
			chk("pad_pullup", e[3], pu);
			chk("pad_slew", e[4], sl);
			chk("pad_high_drive", e[5], hd);
			chk("periph_in", e[6], pi);
			chk("reg_rdata", {14'h0, er}, {14'h0, rdat});
		end
		armed = 1'b1;
		ow = ~an & ((pe & poe) | (~pe & m[1]));
		ix = ~(an | OOM);
		rv = (m[1] & m[0]) | (~m[1] & ix & pin);
		k = kd(adr);
		b = 8 * int'(adr < 8'h06 ? adr[2:1] : adr[3:2]);
		w = (b == 16) ? 6 : 8;
		v = (k == 0) ? rv : (k > 0 ? m[k] : 22'h0);
		er = 8'h00;
		e = '{ow, (pe & pov) | (~pe & m[0]), ix, m[2] & ~ow & ~an, m[3] & ow, m[4] & ow, pin & ix};
		for (int i = 0; i < w; i++) begin
			if (rd && k >= 0)
				er[i] = v[b + i];
			if (wr && k >= 0)
				m[k][b + i] = wd[i];
		end
		if (sys_rst) begin
			m = '{default: 22'h0};
			e = '{default: 22'h0};
			er = 8'h00;
		end
	end
	initial begin
		logic [31:0] r;
		bit rs;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 32; a++) begin
			op(1'b1, 1'b0, 8'(a), 8'($random(seed)));
			op(1'b0, 1'b1, 8'(a), 8'h00);
		end
		op(1'b1, 1'b0, 8'h04, 8'h2a);
		op(1'b1, 1'b0, 8'h05, 8'h3f);
		op(1'b1, 1'b0, 8'h10, 8'hff);
		for (int n = 0; n < 600; n++) begin
			rs = n >= 299 && n <= 301;
			r = $random(seed);
			sys_rst <= (n == 300) || (n == 301);
			pe <= rs ? 22'h0 : 22'(r) & 22'($random(seed));
			an <= rs ? 22'h0 : 22'($random(seed)) & 22'($random(seed)) & 22'(r >> 8);
			poe <= 22'($random(seed));
			pov <= 22'($random(seed));
			xe <= 22'($random(seed));
			xv <= 22'($random(seed));
			op(r[0] & !rs, r[1] & !r[0] & !rs, {3'h0, r[6:2]}, r[31:24]);
		end
		op(1'b0, 1'b0, 8'h00, 8'h00);
		repeat (3) @(posedge clk);
		report_and_stop;
	end
	initial begin
		#(20 * 2000);
		bad_count++;
		report_and_stop;
	end
endmodule
